// file: rtl/gpio_bank_defines.svh
`ifndef GPIO_BANK_DEFINES_SVH
`define GPIO_BANK_DEFINES_SVH
// Behaviour
// R01 - Pins 16..31 each own a 2-bit select field, pin 16 lowest, pin 31 highest
// R02 - Select fields are read/write, reset to zero, survive non-fundamental resets
// R03 - Select code 0 picks first function, 1 second, 2 and 3 pick nothing
// R04 - General-purpose pin with direction bit one is driven as output
// R05 - General-purpose pin with direction bit zero is an undriven input
// R06 - Alternate-function pin ignores direction; the function alone drives it
// R07 - Lower direction and level bits 31:0 map to pins 0..31
// R08 - Upper direction and level bits 21:0 map to pins 32..53
// R09 - Level reads return present sampled pin levels in every mode
// R10 - Level writes change only pins set up as general-purpose outputs
// R11 - Upper register bits 31:22 read zero and ignore writes
// R12 - Level latch cleared to zero at reset; direction resets to all inputs

// ==========================================================
// Bus geometry
`define GB_ADDR_W        12
`define GB_DATA_W        32

// ==========================================================
// Register offsets
`define GB_OFS_FSEL_HI   12'ha9c
`define GB_OFS_DIR_LO    12'haa8
`define GB_OFS_DIR_HI    12'haac
`define GB_OFS_LVL_LO    12'hab0
`define GB_OFS_LVL_HI    12'hab4
`define GB_OFS_ALT_LO    12'hac0
`define GB_OFS_ALT_HI    12'hac4

// ==========================================================
// Field layout
`define GB_PIN_COUNT     54
`define GB_LO_PINS       32
`define GB_FSEL_BASE     16
`define GB_FSEL_PINS     16
`define GB_FSEL_W        2

// ==========================================================
// Reset values
`define GB_RST_FSEL      32'h0000_0000
`define GB_RST_WORD      32'h0000_0000
`define GB_RST_BIT       1'h0

`endif

// file: rtl/gpio_bank_pkg.sv
package gpio_bank_pkg;

  typedef enum logic [1:0] {
    FSEL_FIRST  = 2'h0,
    FSEL_SECOND = 2'h1,
    FSEL_RSVD2  = 2'h2,
    FSEL_RSVD3  = 2'h3
  } fsel_code_t;

endpackage

// file: rtl/gpio_level_if.sv
`timescale 1ns/1ps

interface gpio_level_if #(
  parameter int W = 54
);
  logic [W-1:0] level;

  modport src (output level);
  modport dst (input  level);
endinterface

// file: rtl/gpio_pin_bank_control.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "gpio_bank_defines.svh"

module gpio_pin_bank_control
  import gpio_bank_pkg::*;
#(
  parameter int PIN_COUNT = `GB_PIN_COUNT
) (
  input  wire logic                  sys_clk,     // Core clock, 50 MHz
  input  wire logic                  resetn,      // Async fundamental reset, low
  input  wire logic [`GB_ADDR_W-1:0] addr,        // Register byte address
  input  wire logic [`GB_DATA_W-1:0] wdata,       // Write data
  input  wire logic                  wr_stb,      // Write strobe
  input  wire logic                  rd_stb,      // Read strobe
  output logic      [`GB_DATA_W-1:0] rdata,       // Read data, cycle after strobe
  input  wire logic [PIN_COUNT-1:0]  pin_in,      // Pad input levels
  output logic      [PIN_COUNT-1:0]  pin_out,     // Pad output levels
  output logic      [PIN_COUNT-1:0]  pin_oe,      // Pad output enables, high drives
  input  wire logic [PIN_COUNT-1:0]  first_alternate_function_out,   // First function level
  input  wire logic [PIN_COUNT-1:0]  first_alternate_function_oe,    // First function enable
  input  wire logic [PIN_COUNT-1:0]  second_alternate_function_out,  // Second function level
  input  wire logic [PIN_COUNT-1:0]  second_alternate_function_oe    // Second function enable
);

  localparam int N    = PIN_COUNT;
  localparam int LO   = `GB_LO_PINS;
  localparam int HI_W = N - LO;

  generate
    if (N <= LO || N > 2 * LO) begin : g_chk
      $error("PIN_COUNT must lie between 33 and 64");
    end
  endgenerate

  // ==========================================================
  // Helpers
  function automatic logic [N-1:0] split_write(input logic [N-1:0]          old,
                                               input logic [`GB_DATA_W-1:0] wd,
                                               input logic                  lo_hit,
                                               input logic                  hi_hit);
    logic [N-1:0] res;
    res = old;
    if (lo_hit) begin
      res[LO-1:0] = wd;
    end
    if (hi_hit) begin
      res[N-1:LO] = wd[HI_W-1:0];
    end
    return res;
  endfunction

  function automatic fsel_code_t pin_code(input logic [`GB_DATA_W-1:0] f,
                                          input int                    idx);
    return fsel_code_t'(f[idx*`GB_FSEL_W +: `GB_FSEL_W]);
  endfunction

  // ==========================================================
  // State
  logic [`GB_DATA_W-1:0] fsel_reg;
  logic [`GB_DATA_W-1:0] fsel_next;
  logic [N-1:0]          dir_reg;
  logic [N-1:0]          dir_next;
  logic [N-1:0]          alt_reg;
  logic [N-1:0]          alt_next;
  logic [N-1:0]          latch_reg;
  logic [N-1:0]          latch_next;
  logic [`GB_DATA_W-1:0] rdata_reg;
  logic [`GB_DATA_W-1:0] rdata_next;
  logic [N-1:0]          pin_out_reg;
  logic [N-1:0]          pin_oe_reg;
  logic [N-1:0]          drive_out_next;
  logic [N-1:0]          drive_oe_next;
  logic [N-1:0]          af_out;
  logic [N-1:0]          af_oe;
  logic [N-1:0]          gpio_out_mask;
  logic [N-1:0]          written;
  logic                  first_cycle_reg;

  gpio_level_if #(.W(N)) level_bus ();

  pin_level_sync #(.W(N)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .raw     (pin_in),
    .sync    (level_bus.src)
  );

  // ==========================================================
  // Address decode
  wire hit_fsel   = (addr == `GB_OFS_FSEL_HI);
  wire hit_dir_lo = (addr == `GB_OFS_DIR_LO);
  wire hit_dir_hi = (addr == `GB_OFS_DIR_HI);
  wire hit_lvl_lo = (addr == `GB_OFS_LVL_LO);
  wire hit_lvl_hi = (addr == `GB_OFS_LVL_HI);
  wire hit_alt_lo = (addr == `GB_OFS_ALT_LO);
  wire hit_alt_hi = (addr == `GB_OFS_ALT_HI);
  wire wr_fsel    = wr_stb && hit_fsel;
  wire wr_lvl_lo  = wr_stb && hit_lvl_lo;
  wire wr_lvl_hi  = wr_stb && hit_lvl_hi;

  // ==========================================================
  // Register writes
  assign fsel_next = wr_fsel ? wdata : fsel_reg;  // R01 R02
  assign dir_next  = split_write(dir_reg, wdata,
                                 wr_stb && hit_dir_lo, wr_stb && hit_dir_hi);  // R07 R08 R11
  assign alt_next  = split_write(alt_reg, wdata,
                                 wr_stb && hit_alt_lo, wr_stb && hit_alt_hi);

  // Only pins that are GPIO outputs at write time take the new level
  assign gpio_out_mask = dir_reg & ~alt_reg;
  assign written       = split_write(latch_reg, wdata, wr_lvl_lo, wr_lvl_hi);
  assign latch_next    = (written & gpio_out_mask) | (latch_reg & ~gpio_out_mask);  // R10

  // ==========================================================
  // Read path; unmapped addresses and idle cycles return zero
  wire [`GB_DATA_W-1:0] rd_mux =
      hit_fsel   ? fsel_reg                                          :  // R01
      hit_dir_lo ? dir_reg[LO-1:0]                                   :  // R07
      hit_dir_hi ? `GB_DATA_W'(dir_reg[N-1:LO])                      :  // R08 R11
      hit_lvl_lo ? level_bus.level[LO-1:0]                           :  // R07 R09
      hit_lvl_hi ? `GB_DATA_W'(level_bus.level[N-1:LO])              :  // R08 R09 R11
      hit_alt_lo ? alt_reg[LO-1:0]                                   :
      hit_alt_hi ? `GB_DATA_W'(alt_reg[N-1:LO])                      :
                   `GB_RST_WORD;
  assign rdata_next = rd_stb ? rd_mux : `GB_RST_WORD;

  // ==========================================================
  // Alternate function routing per pin
  genvar p;
  generate
    for (p = 0; p < N; p++) begin : g_pin
      if (p >= `GB_FSEL_BASE && p < `GB_FSEL_BASE + `GB_FSEL_PINS) begin : g_sel
        // Reserved codes leave the pad undriven rather than guess a function
        fsel_code_t code;
        assign code = pin_code(fsel_reg, p - `GB_FSEL_BASE);  // R01
        assign af_out[p] = (code == FSEL_SECOND) ? second_alternate_function_out[p] :
                                                   first_alternate_function_out[p];  // R03
        assign af_oe[p]  = (code == FSEL_FIRST)  ? first_alternate_function_oe[p]  :
                           (code == FSEL_SECOND) ? second_alternate_function_oe[p] :
                                                   1'b0;  // R03
      end else begin : g_fix
        // Selectors for these pins live elsewhere; first function assumed
        assign af_out[p] = first_alternate_function_out[p];
        assign af_oe[p]  = first_alternate_function_oe[p];
      end
    end
  endgenerate

  assign drive_oe_next  = (alt_reg & af_oe)  | (~alt_reg & dir_reg);    // R04 R05 R06
  assign drive_out_next = (alt_reg & af_out) | (~alt_reg & latch_reg);  // R04 R06

  // ==========================================================
  // Flops. Only fundamental reset exists here, so sticky needs nothing extra
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fsel_reg  <= `GB_RST_FSEL;  // R02
      dir_reg   <= '0;            // R12
      alt_reg   <= '0;
      latch_reg <= '0;            // R12
    end else begin
      fsel_reg  <= fsel_next;
      dir_reg   <= dir_next;
      alt_reg   <= alt_next;
      latch_reg <= latch_next;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg   <= `GB_RST_WORD;
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;  // R05 R12
    end else begin
      rdata_reg   <= rdata_next;
      pin_out_reg <= drive_out_next;
      pin_oe_reg  <= drive_oe_next;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      first_cycle_reg <= 1'b1;
    end else begin
      first_cycle_reg <= 1'b0;
    end
  end

  assign rdata   = rdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_fsel_write;
    wr_stb && hit_fsel;
  endsequence

  sequence s_fsel_read;
    rd_stb && hit_fsel;
  endsequence

  sequence s_dir_lo_write;
    wr_stb && hit_dir_lo;
  endsequence

  sequence s_dir_hi_write;
    wr_stb && hit_dir_hi;
  endsequence

  sequence s_dir_hi_read;
    rd_stb && hit_dir_hi;
  endsequence

  a_fsel_read_back: assert property ( // R01
    s_fsel_write ##1 s_fsel_read |=> rdata == $past(wdata, 2))
    else $error("select register read back differs from written value");

  a_fsel_holds_value: assert property ( // R02
    !(wr_stb && hit_fsel) |=> $stable(fsel_reg))
    else $error("select register changed without a write");

  a_reserved_no_drive: assert property ( // R03
    (alt_reg[`GB_FSEL_BASE] &&
     fsel_reg[`GB_FSEL_W-1:0] >= 2'h2) |=> !pin_oe[`GB_FSEL_BASE])
    else $error("reserved select code drove the pad");

  a_second_func_en: assert property ( // R03
    (alt_reg[`GB_FSEL_BASE + `GB_FSEL_PINS - 1] &&
     fsel_reg[`GB_DATA_W-1 -: `GB_FSEL_W] == 2'h1)
    |=> pin_oe[`GB_FSEL_BASE + `GB_FSEL_PINS - 1] ==
        $past(second_alternate_function_oe[`GB_FSEL_BASE + `GB_FSEL_PINS - 1]))
    else $error("second function enable not routed to highest select pin");

  a_gpio_out_drive: assert property ( // R04
    1'b1 |=> ((pin_oe & $past(gpio_out_mask)) == $past(gpio_out_mask)) &&
             ((pin_out ^ $past(latch_reg)) & $past(gpio_out_mask)) == '0)
    else $error("general-purpose output pin not driven with latch level");

  a_gpio_in_float: assert property ( // R05
    1'b1 |=> (pin_oe & $past(~alt_reg & ~dir_reg)) == '0)
    else $error("general-purpose input pin was driven");

  a_alt_owns_pin: assert property ( // R06
    1'b1 |=> ((pin_oe ^ $past(af_oe)) & $past(alt_reg)) == '0)
    else $error("alternate pin enable does not follow its function");

  a_lo_level_map: assert property ( // R07
    rd_stb && hit_lvl_lo |=> rdata == $past(level_bus.level[LO-1:0]))
    else $error("lower level read does not show pins 0 to 31");

  a_hi_level_map: assert property ( // R08
    rd_stb && hit_lvl_hi |=> rdata == `GB_DATA_W'($past(level_bus.level[N-1:LO])))
    else $error("upper level read does not show upper pins");

  a_level_is_live: assert property ( // R09
    rd_stb && hit_lvl_lo && alt_reg[0]
    |=> rdata[0] == $past(level_bus.level[0]))
    else $error("alternate pin level not visible to software");

  a_write_masked: assert property ( // R10
    wr_stb && hit_lvl_lo
    |=> (((latch_reg ^ $past(latch_reg)) & ~$past(gpio_out_mask)) == '0) &&
        (((latch_reg[LO-1:0] ^ $past(wdata)) & $past(gpio_out_mask[LO-1:0])) == '0))
    else $error("level write touched non-output pins or missed outputs");

  a_hi_reserved_zero: assert property ( // R11
    rd_stb && (hit_dir_hi || hit_lvl_hi) |=> rdata[`GB_DATA_W-1:HI_W] == '0)
    else $error("upper reserved bits read non-zero");

  a_reset_all_inputs: assert property ( // R12
    first_cycle_reg |-> dir_reg == '0 && pin_oe == '0)
    else $error("pins not inputs after reset");

  a_fsel_write_lands: assert property ( // R01
    s_fsel_write |=> fsel_reg == $past(wdata))
    else $error("select register did not take the written value");

  a_fsel_reset_zero: assert property ( // R02
    first_cycle_reg |-> fsel_reg == `GB_RST_FSEL)
    else $error("select register not zero after reset");

  // Pins 16 and 31 stand for the whole select range; routing is per-pin generate
  a_first_func_en: assert property ( // R03
    alt_reg[`GB_FSEL_BASE] && fsel_reg[`GB_FSEL_W-1:0] == 2'h0
    |=> pin_oe[`GB_FSEL_BASE] == $past(first_alternate_function_oe[`GB_FSEL_BASE]))
    else $error("first function enable not routed to lowest select pin");

  a_first_func_out: assert property ( // R03
    alt_reg[`GB_FSEL_BASE] && fsel_reg[`GB_FSEL_W-1:0] == 2'h0
    |=> pin_out[`GB_FSEL_BASE] == $past(first_alternate_function_out[`GB_FSEL_BASE]))
    else $error("first function level not routed to lowest select pin");

  a_second_func_out: assert property ( // R03
    (alt_reg[`GB_FSEL_BASE + `GB_FSEL_PINS - 1] &&
     fsel_reg[`GB_DATA_W-1 -: `GB_FSEL_W] == 2'h1)
    |=> pin_out[`GB_FSEL_BASE + `GB_FSEL_PINS - 1] ==
        $past(second_alternate_function_out[`GB_FSEL_BASE + `GB_FSEL_PINS - 1]))
    else $error("second function level not routed to highest select pin");

  a_reserved_hi_no_drive: assert property ( // R03
    (alt_reg[`GB_FSEL_BASE + `GB_FSEL_PINS - 1] &&
     fsel_reg[`GB_DATA_W-1 -: `GB_FSEL_W] >= 2'h2)
    |=> !pin_oe[`GB_FSEL_BASE + `GB_FSEL_PINS - 1])
    else $error("reserved select code drove the highest select pin");

  a_dir_holds_value: assert property ( // R04
    !(wr_stb && (hit_dir_lo || hit_dir_hi)) |=> $stable(dir_reg))
    else $error("direction changed without a write");

  a_dir_lo_lands: assert property ( // R07
    s_dir_lo_write |=> dir_reg[LO-1:0] == $past(wdata))
    else $error("lower direction write did not land on pins 0 to 31");

  a_dir_hi_lands: assert property ( // R08
    s_dir_hi_write |=> dir_reg[N-1:LO] == $past(wdata[HI_W-1:0]))
    else $error("upper direction write did not land on upper pins");

  a_dir_hi_read_back: assert property ( // R11
    s_dir_hi_write ##1 s_dir_hi_read |=> rdata == `GB_DATA_W'($past(wdata[HI_W-1:0], 2)))
    else $error("upper direction read back differs from written bits");

  a_alt_out_follows: assert property ( // R06
    1'b1 |=> ((pin_out ^ $past(af_out)) & $past(alt_reg & af_oe)) == '0)
    else $error("alternate pin level does not follow its function");

  // Pins outside the select range always take the first function
  a_fixed_pin_en: assert property ( // R06
    alt_reg[0] |=> pin_oe[0] == $past(first_alternate_function_oe[0]))
    else $error("pin 0 enable does not follow the first function");

  a_fixed_pin_out: assert property ( // R06
    alt_reg[0] |=> pin_out[0] == $past(first_alternate_function_out[0]))
    else $error("pin 0 level does not follow the first function");

  a_latch_holds_value: assert property ( // R10
    !(wr_lvl_lo || wr_lvl_hi) |=> $stable(latch_reg))
    else $error("output latch changed without a level write");

  a_hi_write_masked: assert property ( // R10
    wr_lvl_hi
    |=> ((latch_reg[N-1:LO] ^ $past(wdata[HI_W-1:0])) & $past(gpio_out_mask[N-1:LO])) == '0)
    else $error("upper level write missed an output pin");

  a_reset_latch_low: assert property ( // R12
    first_cycle_reg |-> latch_reg == '0)
    else $error("output latch not cleared by reset");

endmodule

// file: rtl/pin_level_sync.sv
`timescale 1ns/1ps

module pin_level_sync #(
  parameter int W = 54
) (
  input  wire logic         sys_clk,  // Core clock
  input  wire logic         resetn,   // Async reset, active low
  input  wire logic [W-1:0] raw,      // Asynchronous pin levels
  gpio_level_if.src         sync      // Two-stage sampled levels
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  generate
    if (W < 1) begin : g_chk
      $error("pin_level_sync needs at least one pin");
    end
  endgenerate

  // ==========================================================
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= raw;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync.level = stage2_reg;

endmodule

// file: tb/gpio_pin_bank_control_tb_top.sv
`timescale 1ns/1ps
`include "gpio_bank_defines.svh"

module gpio_pin_bank_control_tb_top;
  import gpio_bank_pkg::*;
  localparam int N = 54;
  logic                  sys_clk = 1'b0;
  logic                  resetn = 1'b0;
  logic [`GB_ADDR_W-1:0] addr;
  logic [31:0]           wdata;
  logic                  wr_stb;
  logic                  rd_stb;
  logic [31:0]           rdata;
  logic [N-1:0]          pin_in, pin_out, pin_oe, board_drv, board_oe;
  logic [N-1:0]          first_alternate_function_out, first_alternate_function_oe;
  logic [N-1:0]          second_alternate_function_out, second_alternate_function_oe;
  logic [N-1:0]          eoe, eout;
  logic [31:0]           exp_q[$];
  logic [31:0]           r, w, w2, seed;
  logic                  rd_seen = 1'b0;
  int                    fails = 0;
  int                    tests_run = 0;

  always #10 sys_clk = ~sys_clk;

  gpio_pin_bank_control #(.PIN_COUNT(N)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .first_alternate_function_out(first_alternate_function_out),
    .first_alternate_function_oe(first_alternate_function_oe),
    .second_alternate_function_out(second_alternate_function_out),
    .second_alternate_function_oe(second_alternate_function_oe));

  pin_board_model #(.W(N)) board (
    .pin_out(pin_out), .pin_oe(pin_oe), .board_drv(board_drv),
    .board_oe(board_oe), .pin_in(pin_in));

  // ==========================================================
  // Bus tasks and compares
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask

  // Write then read with no gap, so read-back checks see adjacent strobes
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, e);
    exp_q.push_back(e);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e) begin
      fails++;
      $display("unexpected read data at %0t: got %h want %h", $time, got, e);
    end
  endtask

  task automatic check_pins(input logic [N-1:0] got, e, m);
    tests_run++;
    if ((got & m) !== (e & m)) begin
      fails++;
      $display("unexpected pads at %0t: got %h want %h", $time, got & m, e & m);
    end
  endtask

  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("counts: %0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Read data only stands in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      check_word(rdata, exp_q.pop_front());
    end
    rd_seen <= rd_stb;
  end

  initial begin
    repeat (2000) @(posedge sys_clk);
    fails++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    addr = '0; wdata = '0; wr_stb = 1'b0; rd_stb = 1'b0;
    first_alternate_function_out = '0;
    first_alternate_function_oe = '0;
    second_alternate_function_out = '0;
    second_alternate_function_oe = '0;
    board_drv = '0; board_oe = '1;
    seed = $urandom(32'h081dcb1d);
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    check_pins(pin_oe, '0, '1);
    rd(`GB_OFS_FSEL_HI, 32'h0);
    rd(`GB_OFS_DIR_LO, 32'h0);
    rd(`GB_OFS_DIR_HI, 32'h0);
    $display("test reset done");

    r = $urandom;
    wr_rd(`GB_OFS_FSEL_HI, r, r);
    wr_rd(`GB_OFS_DIR_HI, 32'hffff_ffff, 32'h003f_ffff);
    wr_rd(`GB_OFS_ALT_HI, 32'hffff_ffff, 32'h003f_ffff);
    wr(`GB_OFS_ALT_HI, 32'h0);
    rd(12'h000, 32'h0);
    $display("test register access done");

    board_drv <= N'({$urandom, $urandom});
    r = $urandom;
    w = $urandom;
    w2 = $urandom;
    wr(`GB_OFS_DIR_LO, r);
    wr(`GB_OFS_LVL_LO, w);
    wr(`GB_OFS_LVL_HI, w2);
    settle();
    check_pins(pin_oe, {22'h3f_ffff, r}, '1);
    check_pins(pin_out, {w2[21:0], w}, {22'h3f_ffff, r});
    rd(`GB_OFS_LVL_LO, (w & r) | (board_drv[31:0] & ~r));
    rd(`GB_OFS_LVL_HI, {10'h0, w2[21:0]});
    // Writes to inputs must not leak into the latch
    wr(`GB_OFS_DIR_HI, 32'h0);
    board_oe <= {22'h0, 32'hffff_ffff};
    wr(`GB_OFS_LVL_HI, ~w2);
    settle();
    rd(`GB_OFS_LVL_HI, 32'h003f_ffff);
    wr(`GB_OFS_DIR_HI, 32'hffff_ffff);
    settle();
    check_pins(pin_out, {w2[21:0], 32'h0}, {22'h3f_ffff, 32'h0});
    $display("test general purpose pads done");

    wr_rd(`GB_OFS_ALT_LO, 32'hffff_ffff, 32'hffff_ffff);
    for (int c = 0; c < 4; c++) begin
      @(posedge sys_clk);
      first_alternate_function_out  <= N'({$urandom, $urandom});
      first_alternate_function_oe   <= N'({$urandom, $urandom});
      second_alternate_function_out <= N'({$urandom, $urandom});
      second_alternate_function_oe  <= N'({$urandom, $urandom});
      wr(`GB_OFS_FSEL_HI, {16{2'(c)}});
      settle();
      eoe = (c == 0) ? first_alternate_function_oe  :
            (c == 1) ? second_alternate_function_oe : '0;
      eout = (c == 1) ? second_alternate_function_out : first_alternate_function_out;
      eoe[15:0] = first_alternate_function_oe[15:0];
      eout[15:0] = first_alternate_function_out[15:0];
      check_pins(pin_oe, eoe, N'(32'hffff_ffff));
      check_pins(pin_out, eout, eoe & N'(32'hffff_ffff));
      rd(`GB_OFS_LVL_LO, (eoe[31:0] & eout[31:0]) | (~eoe[31:0] & board_drv[31:0]));
    end
    $display("test alternate functions done");
    repeat (3) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule

// file: tb/pin_board_model.sv
`timescale 1ns/1ps

module pin_board_model #(
  parameter int W = 54
) (
  input  wire logic [W-1:0] pin_out,    // Pad levels from the bank
  input  wire logic [W-1:0] pin_oe,     // Pad enables from the bank
  input  wire logic [W-1:0] board_drv,  // Level the board drives
  input  wire logic [W-1:0] board_oe,   // Board drive enables
  output logic      [W-1:0] pin_in      // Resolved pad level
);
  // ==========================================================
  // Pad resolution
  // Bank drive wins so a clash never shows as a board value;
  // an undriven pad floats high through the board pull-up
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & board_oe & board_drv)
                | (~pin_oe & ~board_oe);
endmodule
